// ### hw/cri_pkg.sv
// Constants for the invert-file instruction unit.
// Assumes a single 10 MHz core clock and a plain register port.
package cri_pkg;
    localparam int          CLK_PERIOD_NS = 100;
    localparam int          AW            = 4;
    localparam logic [3:0]  OFF_CTRL      = 4'h0;
    localparam logic [3:0]  OFF_BANK      = 4'h1;
    localparam logic [3:0]  OFF_INDEX     = 4'h2;
    localparam logic [3:0]  OFF_INSTR     = 4'h3;
    localparam logic [3:0]  OFF_ACC       = 4'h4;
    localparam logic [3:0]  OFF_STATUS    = 4'h5;
    localparam logic [3:0]  OFF_MADDR     = 4'h6;
    localparam logic [3:0]  OFF_MDATA     = 4'h7;
    localparam int          CTRL_EXT_BIT  = 0;
    localparam int          ST_C          = 0;
    localparam int          ST_DC         = 1;
    localparam int          ST_Z          = 2;
    localparam int          ST_OV         = 3;
    localparam int          ST_N          = 4;
    localparam int          ST_BUSY       = 5;
    localparam int          ST_BAD        = 6;
    localparam logic [5:0]  OPC_INVERT    = 6'h07;
    localparam int          OPC_LSB       = 10;
    localparam int          DEST_BIT      = 9;
    localparam int          ACC_BIT       = 8;
    localparam logic [7:0]  IDX_LIMIT     = 8'h5F;
    localparam logic [7:0]  ACCESS_SPLIT  = 8'h80;
    localparam logic [3:0]  ACCESS_HI     = 4'hF;
    localparam logic [3:0]  ACCESS_LO     = 4'h0;
    localparam int          MEM_DEPTH     = 4096;
    localparam logic [4:0]  STATUS_RST    = 5'h00;
    typedef enum logic [4:0] {
        PH_IDLE = 5'b00001,
        PH_Q1   = 5'b00010,
        PH_Q2   = 5'b00100,
        PH_Q3   = 5'b01000,
        PH_Q4   = 5'b10000
    } cri_phase_type;
endpackage

// ### hw/cri_invert_unit.sv
// Executes the byte-inverting file instruction over four quarter phases.
// Assumes a register master that never holds both strobes at once.
// Behaviour
// - read the addressed byte and form its bitwise complement as result
// - only negative and zero flags change; other status flags keep value
// - recognise opcode bits 000111, then destination, access and 8-bit address
// - destination 0 writes accumulator, destination 1 writes the byte back
// - access bit 0 resolves the address in the access bank, pointer ignored
// - access bit 1 takes the bank from the bank pointer
// - extended set, access 0, address up to 95 uses indexed literal offset
// - one program word, finishes in one instruction cycle
// - decode Q1, read Q2, compute Q3, write destination Q4
`timescale 1ns/1ps
module cri_invert_unit
    import cri_pkg::*;
(
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    input  wire logic [AW-1:0] reg_addr,
    input  wire logic [15:0]   reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic      [15:0]   reg_rdata,
    output logic               busy
);
    import cri_pkg::*;

    logic [7:0]    mem [MEM_DEPTH];
    cri_phase_type state_q, state_d;
    logic [15:0]   instr_q, instr_d;
    logic [11:0]   addr_q, addr_d;
    logic [7:0]    op_q, op_d, res_q, res_d, acc_q, acc_d;
    logic [3:0]    bank_q, bank_d;
    logic [11:0]   index_q, index_d, maddr_q, maddr_d;
    logic          ext_q, ext_d, bad_q, bad_d;
    logic [4:0]    st_q, st_d;
    logic [15:0]   rdata_q, rdata_d;
    logic          idle, start, mem_wr_bus, mem_wr_op;
    logic [7:0]    fld;

    assign idle       = (state_q == PH_IDLE);
    assign start      = reg_wr && idle && (reg_addr == OFF_INSTR);
    assign mem_wr_bus = reg_wr && idle && (reg_addr == OFF_MDATA);
    assign mem_wr_op  = (state_q == PH_Q4) && instr_q[DEST_BIT];
    assign fld        = instr_q[7:0];
    assign busy       = !idle;
    assign reg_rdata  = rdata_q;

    // Bus writes land only while idle, so settings hold through an instruction
    always_comb begin
        state_d = state_q;
        instr_d = instr_q;
        addr_d  = addr_q;
        op_d    = op_q;
        res_d   = res_q;
        acc_d   = acc_q;
        bank_d  = bank_q;
        index_d = index_q;
        maddr_d = maddr_q;
        ext_d   = ext_q;
        bad_d   = bad_q;
        st_d    = st_q;
        rdata_d = 16'h0000;
        if (reg_wr && idle) begin
            unique case (reg_addr)
                OFF_CTRL:   ext_d   = reg_wdata[CTRL_EXT_BIT];
                OFF_BANK:   bank_d  = reg_wdata[3:0];
                OFF_INDEX:  index_d = reg_wdata[11:0];
                OFF_ACC:    acc_d   = reg_wdata[7:0];
                OFF_STATUS: st_d    = reg_wdata[4:0];
                OFF_MADDR:  maddr_d = reg_wdata[11:0];
                default: ;
            endcase
        end
        if (start) begin
            instr_d = reg_wdata;
            state_d = PH_Q1;
        end
        unique case (state_q)
            PH_IDLE: ;
            PH_Q1: begin
                if (instr_q[15:OPC_LSB] != OPC_INVERT) begin
                    bad_d   = 1'b1;
                    state_d = PH_IDLE;
                end else begin
                    bad_d   = 1'b0;
                    state_d = PH_Q2;
                    // Operand address is formed here so that Q2 can read the byte
                    if (instr_q[ACC_BIT]) begin
                        addr_d = {bank_q, fld};
                    end else if (ext_q && fld <= IDX_LIMIT) begin
                        addr_d = index_q + {4'h0, fld};
                    end else begin
                        addr_d = {(fld >= ACCESS_SPLIT) ? ACCESS_HI : ACCESS_LO, fld};
                    end
                end
            end
            PH_Q2: begin
                op_d    = mem[addr_q];
                state_d = PH_Q3;
            end
            PH_Q3: begin
                res_d   = ~op_q;
                state_d = PH_Q4;
            end
            PH_Q4: begin
                if (!instr_q[DEST_BIT]) begin
                    acc_d = res_q;
                end
                st_d[ST_N] = res_q[7];
                st_d[ST_Z] = (res_q == 8'h00);
                state_d    = PH_IDLE;
            end
            default: state_d = PH_IDLE;
        endcase
        if (reg_rd) begin
            unique case (reg_addr)
                OFF_CTRL:   rdata_d = {15'h0000, ext_q};
                OFF_BANK:   rdata_d = {12'h000, bank_q};
                OFF_INDEX:  rdata_d = {4'h0, index_q};
                OFF_INSTR:  rdata_d = instr_q;
                OFF_ACC:    rdata_d = {8'h00, acc_q};
                OFF_STATUS: rdata_d = {9'h000, bad_q, busy, st_q};
                OFF_MADDR:  rdata_d = {4'h0, maddr_q};
                OFF_MDATA:  rdata_d = {8'h00, mem[maddr_q]};
                default:    rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= PH_IDLE;
            instr_q <= 16'h0000;
            addr_q  <= 12'h000;
            op_q    <= 8'h00;
            res_q   <= 8'h00;
            acc_q   <= 8'h00;
            bank_q  <= 4'h0;
            index_q <= 12'h000;
            maddr_q <= 12'h000;
            ext_q   <= 1'b0;
            bad_q   <= 1'b0;
            st_q    <= STATUS_RST;
            rdata_q <= 16'h0000;
        end else begin
            state_q <= state_d;
            instr_q <= instr_d;
            addr_q  <= addr_d;
            op_q    <= op_d;
            res_q   <= res_d;
            acc_q   <= acc_d;
            bank_q  <= bank_d;
            index_q <= index_d;
            maddr_q <= maddr_d;
            ext_q   <= ext_d;
            bad_q   <= bad_d;
            st_q    <= st_d;
            rdata_q <= rdata_d;
        end
    end

    // Data memory has no reset; bus writes only while idle
    always_ff @(posedge core_clk) begin
        if (mem_wr_op) begin
            mem[addr_q] <= res_q;
        end else if (mem_wr_bus) begin
            mem[maddr_q] <= reg_wdata[7:0];
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    AST_RESULT: assert property ((state_q == PH_Q3) |=> res_q == ~$past(op_q))
        else $error("result is not the complement of the operand");
    AST_OTHER_FLAGS: assert property ((state_q == PH_Q4)
        |=> {st_q[ST_C], st_q[ST_DC], st_q[ST_OV]} == $past({st_q[ST_C], st_q[ST_DC], st_q[ST_OV]}))
        else $error("carry, digit carry or overflow changed");
    AST_FLAGS_HOLD: assert property ((state_q != PH_Q4) && !(reg_wr && idle && reg_addr == OFF_STATUS)
        |=> st_q == $past(st_q))
        else $error("status flags changed outside a status write or Q4");
    AST_NZ: assert property ((state_q == PH_Q4)
        |=> st_q[ST_N] == $past(res_q[7]) && st_q[ST_Z] == ($past(res_q) == 8'h00))
        else $error("negative or zero flag wrong");
    AST_DECODE: assert property ((state_q == PH_Q1) && (instr_q[15:OPC_LSB] != OPC_INVERT)
        |=> idle && bad_q)
        else $error("foreign opcode was executed");
    AST_DEST_ACC: assert property ((state_q == PH_Q4) && !instr_q[DEST_BIT] |=> acc_q == $past(res_q))
        else $error("accumulator not written");
    AST_ACC_HOLD: assert property (busy && (state_q != PH_Q4) |=> acc_q == $past(acc_q))
        else $error("accumulator changed before the write phase");
    AST_DEST_MEM: assert property ((state_q == PH_Q4) && instr_q[DEST_BIT]
        |=> mem[$past(addr_q)] == $past(res_q) && acc_q == $past(acc_q))
        else $error("memory byte not written back");
    AST_ACCESS: assert property ((state_q == PH_Q1) && instr_q[15:OPC_LSB] == OPC_INVERT && !instr_q[ACC_BIT]
        && !(ext_q && fld <= IDX_LIMIT) |=> addr_q == {$past(fld[7]) ? ACCESS_HI : ACCESS_LO, $past(fld)})
        else $error("access bank address wrong");
    AST_BANK: assert property ((state_q == PH_Q1) && instr_q[15:OPC_LSB] == OPC_INVERT && instr_q[ACC_BIT]
        |=> addr_q == {$past(bank_q), $past(fld)})
        else $error("banked address wrong");
    AST_INDEXED: assert property ((state_q == PH_Q1) && instr_q[15:OPC_LSB] == OPC_INVERT && !instr_q[ACC_BIT]
        && ext_q && fld <= IDX_LIMIT |=> addr_q == $past(index_q) + {4'h0, $past(fld)})
        else $error("indexed literal offset address wrong");
    AST_READ: assert property ((state_q == PH_Q2) |=> op_q == $past(mem[addr_q]))
        else $error("operand not read in Q2");
    AST_PHASES: assert property (start && reg_wdata[15:OPC_LSB] == OPC_INVERT
        |=> (state_q == PH_Q1) ##1 (state_q == PH_Q2) ##1 (state_q == PH_Q3) ##1 (state_q == PH_Q4) ##1 idle)
        else $error("quarter phase order broken");
    // A refused opcode leaves after Q1, so only a decoded word must run all four phases
    AST_ONE_CYCLE: assert property ($rose(busy) && instr_q[15:OPC_LSB] == OPC_INVERT
        |-> busy [*4] ##1 !busy)
        else $error("instruction did not finish in one cycle");

    // Main scenarios: either destination, indexed form, refused opcode, zero result
    COV_TO_ACC: cover property ((state_q == PH_Q4) && !instr_q[DEST_BIT]);
    COV_TO_MEM: cover property ((state_q == PH_Q4) && instr_q[DEST_BIT] && instr_q[ACC_BIT]);
    COV_INDEXED: cover property ((state_q == PH_Q1) && ext_q && !instr_q[ACC_BIT] && fld <= IDX_LIMIT);
    COV_BAD: cover property ((state_q == PH_Q1) && instr_q[15:OPC_LSB] != OPC_INVERT);
    COV_ZERO: cover property ((state_q == PH_Q4) && (res_q == 8'h00));
endmodule

// ### tb/cri_invert_unit_bench.sv
// Self-checking bench for the invert-file instruction unit, with a model of the byte and flags.
// Assumes the unit alone, reached only through its register port on a 10 MHz clock.
`timescale 1ns/1ps
module cri_invert_unit_bench;
    import cri_pkg::*;
    logic          core_clk    = 1'b0;
    logic          rst_n       = 1'b0;
    logic [AW-1:0] reg_addr    = '0;
    logic [15:0]   reg_wdata   = '0;
    logic          reg_wr      = 1'b0;
    logic          reg_rd      = 1'b0;
    logic [15:0]   reg_rdata;
    logic          busy;
    int            fail_count  = 0;
    int            comparisons = 0;
    int            seed        = 68;
    int            cycles      = 0;

    cri_invert_unit i_cri_invert_unit (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .busy(busy));

    always #(CLK_PERIOD_NS/2) core_clk = ~core_clk;

    task automatic tally_and_finish();
        if (fail_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Bounds a hung run
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 8000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
        @(posedge core_clk);
    endtask

    // Issues one instruction, counts busy cycles from Q1 on; poke tries an accumulator write in Q2
    task automatic run(input logic [15:0] w, input bit poke, output int n);
        n = 0;
        reg_wr    <= 1'b1;
        reg_addr  <= OFF_INSTR;
        reg_wdata <= w;
        @(posedge core_clk);
        for (int i = 1; i <= 6; i++) begin
            reg_wr    <= poke && i == 2;
            reg_addr  <= OFF_ACC;
            reg_wdata <= 16'h00A5;
            #1;
            n += (busy === 1'b1);
            @(posedge core_clk);
        end
    endtask

    initial begin
        logic [15:0] w;
        logic [11:0] idx;
        logic [11:0] ad;
        logic [7:0]  f;
        logic [7:0]  v;
        logic [7:0]  acc;
        logic [7:0]  res;
        logic [4:0]  st;
        logic [3:0]  bank;
        logic        ext;
        bit          good;
        int          n;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rd_chk(OFF_STATUS, 16'h0000);
        for (int k = 0; k < 48; k++) begin
            ext  = 1'($random(seed));
            bank = 4'($random(seed));
            idx  = 12'($random(seed));
            w    = 16'($random(seed));
            v    = (k % 5 == 0) ? 8'hFF : 8'($random(seed));
            st   = 5'($random(seed));
            acc  = 8'($random(seed));
            good = (k % 6) != 5;
            if (k % 4 == 0)
                w[8:0] = 9'h05F + 9'((k / 4) % 2);
            if (k % 4 == 1)
                w[8:0] = 9'h080 - 9'((k / 4) % 2);
            if (good)
                w[15:10] = OPC_INVERT;
            else if (w[15:10] == OPC_INVERT)
                w[15] = 1'b1;
            f = w[7:0];
            if (w[ACC_BIT])
                ad = {bank, f};
            else if (ext && f <= IDX_LIMIT)
                ad = idx + 12'(f);
            else
                ad = {(f < ACCESS_SPLIT) ? ACCESS_LO : ACCESS_HI, f};
            wr(OFF_CTRL, {15'h0000, ext});
            wr(OFF_BANK, {12'h000, bank});
            wr(OFF_INDEX, {4'h0, idx});
            wr(OFF_MADDR, {4'h0, ad});
            wr(OFF_MDATA, {8'h00, v});
            wr(OFF_STATUS, {11'h000, st});
            wr(OFF_ACC, {8'h00, acc});
            run(w, good && k % 3 == 0, n);
            chk(16'(n), good ? 16'h0004 : 16'h0001);
            rd_chk(OFF_INSTR, w);
            res = good ? ~v : v;
            if (good && !w[DEST_BIT])
                acc = res;
            if (good) begin
                st[ST_N] = res[7];
                st[ST_Z] = (res == 8'h00);
            end
            rd_chk(OFF_ACC, {8'h00, acc});
            rd_chk(OFF_STATUS, {9'h000, !good, 1'b0, st});
            wr(OFF_MADDR, {4'h0, ad});
            rd_chk(OFF_MDATA, {8'h00, (w[DEST_BIT] ? res : v)});
            rd_chk(4'h8 | 4'($random(seed)), 16'h0000);
        end
        tally_and_finish();
    end
endmodule
